// ### hdl/dsc_cfg.svh
// constants of the spreading code unit: register map, fields, timing
// assumes inclusion by bare name from every file that needs a figure
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define DSC_OFF_TX_HI    12'h000
`define DSC_OFF_TX_LO    12'h004
`define DSC_OFF_RX_HI    12'h008
`define DSC_OFF_RX_LO    12'h00C
`define DSC_OFF_CTRL     12'h010
`define DSC_OFF_THRESH   12'h014
`define DSC_OFF_STATUS   12'h018

// ************************************************************
// field positions and reset values
// ************************************************************
`define DSC_CTRL_TXLEN_LO  5
`define DSC_CTRL_TXLEN_HI  6
`define DSC_CTRL_RXLEN_LO  2
`define DSC_CTRL_RXLEN_HI  3
`define DSC_CTRL_MODE_LO   0
`define DSC_CTRL_MODE_HI   1
`define DSC_CTRL_TXEN      7
`define DSC_RST_CODE       8'h00
`define DSC_RST_CTRL       8'h00
`define DSC_RST_THRESH     5'h0B

// ************************************************************
// length field mapping (chips per data bit)
// ************************************************************
`define DSC_LEN_SEL0       5'h0B
`define DSC_LEN_SEL1       5'h0D
`define DSC_LEN_SEL2       5'h0F
`define DSC_LEN_SEL3       5'h10
`define DSC_LEN_M7         5'h07
`define DSC_LEN_M15        5'h0F
`define DSC_LEN_MAX        5'h10

// ************************************************************
// m-sequence seeds and timing
// ************************************************************
`define DSC_SEED_M7        4'h4
`define DSC_SEED_M15       4'h8
`define DSC_CHIP_DIV       4'h2
`define DSC_LOSS_MAX       3'h4

`endif

// ### hdl/dsc_pkg.sv
// types of the spreading code unit
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package dsc_pkg;
  // code source selection
  typedef enum logic [1:0] {DSC_PROG, DSC_M7, DSC_M15, DSC_PROG_ALT} dsc_mode_t;
  // receiver timing states
  typedef enum logic [0:0] {DSC_SEARCH, DSC_TRACK} dsc_rx_state_t;
endpackage : dsc_pkg

`default_nettype wire

// ### hdl/dsc_corr.sv
// one binary parallel matched filter over up to sixteen chips
// assumes hard-decision chips from logic on the same clock
`default_nettype none

`include "dsc_cfg.svh"

module dsc_corr
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  // chip stream
  input  wire logic       chip_i,
  input  wire logic       chip_vld_i,
  // reference
  input  wire logic [15:0] ref_i,
  input  wire logic [4:0]  len_i,
  // result
  output logic      [4:0]  match_o,
  output logic             match_vld_o
);

  logic [15:0] hist_q;   // chip history, newest in bit 0

  // ************************************************************
  // chip history
  // ************************************************************
  // shift in each new chip
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hist_q <= 16'h0000;
    end
    else if (chip_vld_i)
    begin
      hist_q <= {hist_q[14:0], chip_i};
    end
  end

  // ************************************************************
  // all taps compared at once
  // ************************************************************
  // count agreeing taps inside the length, one cycle after a chip
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      match_o     <= 5'h00;
      match_vld_o <= 1'b0;
    end
    else
    begin
      match_vld_o <= chip_vld_i;
      if (chip_vld_i)
      begin
        match_o <= count_match({hist_q[14:0], chip_i}, ref_i, len_i);
      end
    end
  end

  // agreements over the low len taps
  function automatic logic [4:0] count_match(input logic [15:0] h,
                                             input logic [15:0] r,
                                             input logic [4:0]  n);
    logic [4:0] acc;
    acc = 5'h00;
    for (int k = 0; k < 16; k++)
    begin
      if ((5'(k) < n) && (h[k] == r[k]))
      begin
        acc = acc + 5'h01;
      end
    end
    return acc;
  endfunction

endmodule // dsc_corr

`default_nettype wire

// ### hdl/dsc_unit.sv
// spreading code unit: transmit spreader, receive i/q correlators, apb registers
// assumes apb master and the data source / modulator on core_clk_i
`default_nettype none

`include "dsc_cfg.svh"

// Overview of operation
// - data bit xored with chips, faster
// - chips leave at a constant rate
// - seven-chip m-sequence 0010111, poly 1+x2+x3
// - fifteen-chip m-sequence, poly 1+x3+x4
// - m-sequences from xor-feedback shift register
// - barker codes programmable, lengths eleven and thirteen
// - willard codes programmable by length
// - any pattern of eleven, thirteen, fifteen or sixteen chips
// - same sequence spreads every symbol
// - parallel load then serial shift out
// - transmit code in high and low bytes
// - receive code in its own byte pair
// - control bits five, six pick transmit length; bits two, three pick receive length
// - chips leave most significant first
// - short lengths drop the upper bits
// - separate i and q correlators
// - transmit and receive settings independent
// - parallel time-invariant matched filters
// - correlation peak declares acquisition and timing
// - tracking keeps reference aligned to received code
module dsc_unit
  import dsc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // transmit data source
  input  wire logic        tx_data_i,
  input  wire logic        tx_data_vld_i,
  output logic             tx_data_take_o,
  // transmit chips to modulator
  output logic             tx_chip_o,
  output logic             tx_chip_vld_o,
  output logic             tx_sym_start_o,
  // receive chips from i and q
  input  wire logic        rx_i_chip_i,
  input  wire logic        rx_q_chip_i,
  input  wire logic        rx_chip_vld_i,
  // receive results
  output logic             rx_acq_o,
  output logic             rx_sym_vld_o,
  output logic             rx_data_o
);
  import dsc_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]  tx_code_high_byte_q;   // upper eight transmit chips
  logic [7:0]  tx_code_low_byte_q;    // lower eight transmit chips
  logic [7:0]  rx_code_high_byte_q;   // upper eight reference chips
  logic [7:0]  rx_code_low_byte_q;    // lower eight reference chips
  logic [7:0]  spread_length_control_q; // lengths, mode, enable
  logic [4:0]  thresh_q;              // acquisition threshold
  logic        apb_wr;                // write takes effect
  logic        apb_setup;             // setup phase seen
  logic        addr_ok;               // mapped address
  logic [31:0] rd_mux;                // read data source

  // ************************************************************
  // transmit state
  // ************************************************************
  dsc_mode_t   mode;                  // selected source
  logic [4:0]  tx_len;                // chips per symbol
  logic [15:0] tx_code;               // programmed code
  logic [15:0] tx_sh_q;               // chip shift register
  logic [3:0]  lfsr_q;                // m-sequence state
  logic [4:0]  tx_cnt_q;              // chips left in symbol
  logic [3:0]  div_q;                 // chip rate divider
  logic        chip_tick;             // one chip period elapsed
  logic        tx_bit_q;              // data bit being spread
  logic        tx_run_q;              // symbol in progress
  logic        tx_chip;               // current chip
  logic [3:0]  lfsr_nx;               // next m-sequence state

  // ************************************************************
  // receive state
  // ************************************************************
  dsc_rx_state_t rx_st_q;             // search or track
  logic [4:0]  rx_len;                // reference length
  logic [4:0]  m_i, m_q;              // agreements per channel
  logic        m_vld;                 // agreements valid
  logic        pk_i, pk_q;            // peak on each channel
  logic        peak;                  // peak on either
  logic [4:0]  rx_cnt_q;              // chips since last symbol
  logic [2:0]  loss_q;                // missed peaks in a row

  // ************************************************************
  // apb slave
  // ************************************************************
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;
  assign addr_ok   = (paddr == `DSC_OFF_TX_HI) || (paddr == `DSC_OFF_TX_LO) ||
                     (paddr == `DSC_OFF_RX_HI) || (paddr == `DSC_OFF_RX_LO) ||
                     (paddr == `DSC_OFF_CTRL)  || (paddr == `DSC_OFF_THRESH) ||
                     (paddr == `DSC_OFF_STATUS);

  // read data selection
  always_comb
  begin
    case (paddr)
      `DSC_OFF_TX_HI:  rd_mux = {24'h000000, tx_code_high_byte_q};
      `DSC_OFF_TX_LO:  rd_mux = {24'h000000, tx_code_low_byte_q};
      `DSC_OFF_RX_HI:  rd_mux = {24'h000000, rx_code_high_byte_q};
      `DSC_OFF_RX_LO:  rd_mux = {24'h000000, rx_code_low_byte_q};
      `DSC_OFF_CTRL:   rd_mux = {24'h000000, spread_length_control_q};
      `DSC_OFF_THRESH: rd_mux = {27'h0, thresh_q};
      `DSC_OFF_STATUS: rd_mux = {29'h0, tx_run_q, rx_data_o, rx_acq_o};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // answer in the first access cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      if (apb_setup)
      begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // register writes, low byte lane only
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_code_high_byte_q     <= `DSC_RST_CODE;
      tx_code_low_byte_q      <= `DSC_RST_CODE;
      rx_code_high_byte_q     <= `DSC_RST_CODE;
      rx_code_low_byte_q      <= `DSC_RST_CODE;
      spread_length_control_q <= `DSC_RST_CTRL;
      thresh_q                <= `DSC_RST_THRESH;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `DSC_OFF_TX_HI:  tx_code_high_byte_q     <= pwdata[7:0];
        `DSC_OFF_TX_LO:  tx_code_low_byte_q      <= pwdata[7:0];
        `DSC_OFF_RX_HI:  rx_code_high_byte_q     <= pwdata[7:0];
        `DSC_OFF_RX_LO:  rx_code_low_byte_q      <= pwdata[7:0];
        `DSC_OFF_CTRL:   spread_length_control_q <= pwdata[7:0];
        `DSC_OFF_THRESH: thresh_q                <= pwdata[4:0];
        default:         ;                         // unmapped or status, ignored
      endcase
    end
  end

  // ************************************************************
  // length decode
  // ************************************************************
  // two-bit field to chip count
  function automatic logic [4:0] len_map(input logic [1:0] sel);
    case (sel)
      2'h0:    return `DSC_LEN_SEL0;
      2'h1:    return `DSC_LEN_SEL1;
      2'h2:    return `DSC_LEN_SEL2;
      default: return `DSC_LEN_SEL3;
    endcase
  endfunction

  assign mode    = dsc_mode_t'(spread_length_control_q[`DSC_CTRL_MODE_HI:`DSC_CTRL_MODE_LO]);
  assign tx_code = {tx_code_high_byte_q, tx_code_low_byte_q};

  // chips per symbol for the selected source
  always_comb
  begin
    case (mode)
      DSC_M7:  tx_len = `DSC_LEN_M7;
      DSC_M15: tx_len = `DSC_LEN_M15;
      default: tx_len = len_map(spread_length_control_q[`DSC_CTRL_TXLEN_HI:
                                                        `DSC_CTRL_TXLEN_LO]);
    endcase
  end

  assign rx_len = len_map(spread_length_control_q[`DSC_CTRL_RXLEN_HI:
                                                  `DSC_CTRL_RXLEN_LO]);

  // ************************************************************
  // chip timing
  // ************************************************************
  // fixed divider gives a constant chip rate
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      div_q <= 4'h0;
    end
    else if (chip_tick)
    begin
      div_q <= 4'h0;
    end
    else
    begin
      div_q <= div_q + 4'h1;
    end
  end

  assign chip_tick = (div_q == (`DSC_CHIP_DIV - 4'h1));

  // ************************************************************
  // code generators
  // ************************************************************
  // xor feedback, oldest chip in bit 0
  always_comb
  begin
    if (mode == DSC_M7)
    begin
      lfsr_nx = {1'b0, lfsr_q[1] ^ lfsr_q[0], lfsr_q[2:1]};
    end
    else
    begin
      lfsr_nx = {lfsr_q[1] ^ lfsr_q[0], lfsr_q[3:1]};
    end
  end

  // current chip: m-sequence output or top of the shift register
  assign tx_chip = ((mode == DSC_M7) || (mode == DSC_M15)) ? lfsr_q[0] : tx_sh_q[15];

  // symbol sequencer: take a bit, reload, shift out
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_sh_q  <= 16'h0000;
      lfsr_q   <= 4'h0;
      tx_cnt_q <= 5'h00;
      tx_bit_q <= 1'b0;
      tx_run_q <= 1'b0;
    end
    else if (chip_tick)
    begin
      if (tx_cnt_q > 5'h01)
      begin
        // mid symbol: next chip
        tx_cnt_q <= tx_cnt_q - 5'h01;
        tx_sh_q  <= {tx_sh_q[14:0], 1'b0};
        lfsr_q   <= lfsr_nx;
      end
      else if (spread_length_control_q[`DSC_CTRL_TXEN] & tx_data_vld_i)
      begin
        // boundary: reload the same code for the next bit
        tx_cnt_q <= tx_len;
        tx_bit_q <= tx_data_i;
        tx_run_q <= 1'b1;
        tx_sh_q  <= tx_code << (`DSC_LEN_MAX - tx_len);
        lfsr_q   <= (mode == DSC_M7) ? `DSC_SEED_M7 : `DSC_SEED_M15;
      end
      else
      begin
        // idle: transmit disabled or no data waiting
        tx_cnt_q <= 5'h00;
        tx_run_q <= 1'b0;
      end
    end
  end

  // registered chip outputs, one strobe per chip
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_chip_o      <= 1'b0;
      tx_chip_vld_o  <= 1'b0;
      tx_sym_start_o <= 1'b0;
      tx_data_take_o <= 1'b0;
    end
    else
    begin
      tx_chip_vld_o  <= chip_tick & tx_run_q;
      tx_chip_o      <= tx_bit_q ^ tx_chip;
      tx_sym_start_o <= chip_tick & (tx_cnt_q <= 5'h01) &
                        spread_length_control_q[`DSC_CTRL_TXEN] & tx_data_vld_i;
      tx_data_take_o <= chip_tick & (tx_cnt_q <= 5'h01) &
                        spread_length_control_q[`DSC_CTRL_TXEN] & tx_data_vld_i;
    end
  end

  // ************************************************************
  // receive correlators
  // ************************************************************
  dsc_corr u_corr_i
  (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .chip_i      (rx_i_chip_i),
    .chip_vld_i  (rx_chip_vld_i),
    .ref_i       ({rx_code_high_byte_q, rx_code_low_byte_q}),
    .len_i       (rx_len),
    .match_o     (m_i),
    .match_vld_o (m_vld)
  );

  dsc_corr u_corr_q
  (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .chip_i      (rx_q_chip_i),
    .chip_vld_i  (rx_chip_vld_i),
    .ref_i       ({rx_code_high_byte_q, rx_code_low_byte_q}),
    .len_i       (rx_len),
    .match_o     (m_q),
    .match_vld_o ()
  );

  // peak: strong agreement or strong disagreement (data one)
  assign pk_i = (m_i >= thresh_q) || ((rx_len - m_i) >= thresh_q);
  assign pk_q = (m_q >= thresh_q) || ((rx_len - m_q) >= thresh_q);
  assign peak = m_vld & (pk_i | pk_q);

  // ************************************************************
  // acquisition and tracking
  // ************************************************************
  // search for a peak, then expect one each symbol
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_st_q      <= DSC_SEARCH;
      rx_cnt_q     <= 5'h00;
      loss_q       <= 3'h0;
      rx_acq_o     <= 1'b0;
      rx_sym_vld_o <= 1'b0;
      rx_data_o    <= 1'b0;
    end
    else
    begin
      rx_sym_vld_o <= 1'b0;
      case (rx_st_q)
        DSC_SEARCH:
        begin
          if (peak)
          begin
            // first peak: lock and fix symbol timing
            rx_st_q      <= DSC_TRACK;
            rx_acq_o     <= 1'b1;
            rx_cnt_q     <= 5'h00;
            loss_q       <= 3'h0;
            rx_sym_vld_o <= 1'b1;
            rx_data_o    <= (m_i < (rx_len >> 1));
          end
        end
        DSC_TRACK:
        begin
          if (m_vld)
          begin
            if (peak)
            begin
              // realign timing on every peak
              rx_cnt_q     <= 5'h00;
              loss_q       <= 3'h0;
              rx_sym_vld_o <= 1'b1;
              rx_data_o    <= (m_i < (rx_len >> 1));
            end
            else if (rx_cnt_q == (rx_len - 5'h01))
            begin
              // expected peak missing
              rx_cnt_q <= 5'h00;
              if (loss_q == (`DSC_LOSS_MAX - 3'h1))
              begin
                rx_st_q  <= DSC_SEARCH;
                rx_acq_o <= 1'b0;
              end
              else
              begin
                loss_q <= loss_q + 3'h1;
              end
            end
            else
            begin
              rx_cnt_q <= rx_cnt_q + 5'h01;
            end
          end
        end
        default:
        begin
          rx_st_q <= DSC_SEARCH;
        end
      endcase
    end
  end

endmodule // dsc_unit

`default_nettype wire

// ### tb/dsc_unit_chk.sv
// checker: port relations of the spreading code unit
// assumes binding onto dsc_unit, one clock domain
`default_nettype none

module dsc_unit_chk
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // transmit
  input wire logic tx_data_vld_i,
  input wire logic tx_data_take_o,
  input wire logic tx_chip_vld_o,
  input wire logic tx_sym_start_o,
  // receive
  input wire logic rx_chip_vld_i,
  input wire logic rx_sym_vld_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // *****
  // steps of a bus transfer and a symbol
  // *****
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  sequence first_chip_s;
    !tx_sym_start_o ##1 tx_chip_vld_o;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> access_s)
    else $error("error outside access");
  take_cause_a: assert property (tx_data_take_o |-> $past(tx_data_vld_i) && tx_sym_start_o)
    else $error("bit taken without data");
  chip_pulse_a: assert property (tx_chip_vld_o |=> !tx_chip_vld_o)
    else $error("chip strobe too fast");
  sym_first_chip_a: assert property (tx_sym_start_o |=> first_chip_s)
    else $error("first chip late");
  sym_spacing_a: assert property (tx_sym_start_o |=> !tx_sym_start_o [*8])
    else $error("symbols too close");
  rx_decide_lat_a: assert property (rx_sym_vld_o |-> $past(rx_chip_vld_i, 2))
    else $error("decision without chip");
endmodule // dsc_unit_chk

`default_nettype wire

// ### tb/dsc_src_model.sv
// partner: bit source for the spreader, modulator path capturing chips
// assumes the unit's transmit ports on the same clock
`default_nettype none

module dsc_src_model
(
  // clock and control
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        go_i,
  input  wire logic        clr_i,
  // spreader side
  input  wire logic        tx_data_take_i,
  input  wire logic        tx_chip_i,
  input  wire logic        tx_chip_vld_i,
  output logic             tx_data_o,
  output logic             tx_data_vld_o,
  // loopback and capture
  output logic             rx_i_o,
  output logic             rx_q_o,
  output logic             rx_vld_o,
  output logic      [31:0] chips_o,
  output logic      [5:0]  n_chip_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // *****
  // source and modulator
  // *****
  logic [1:0] idx_q;  // bits handed over
  logic       tgl_q;  // junk once released
  // two bits, 0 then 1; toggling pattern when idle
  assign tx_data_vld_o = go_i && (idx_q < 2'h2);
  assign tx_data_o     = tx_data_vld_o ? idx_q[0] : tgl_q;
  // both correlators fed from the chip stream
  assign rx_i_o   = tx_chip_i;
  assign rx_q_o   = ~tx_chip_i;
  assign rx_vld_o = tx_chip_vld_i;
  // count taken bits, shift in chips in arrival order
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i || clr_i)
    begin
      idx_q    <= 2'h0;
      tgl_q    <= 1'b0;
      chips_o  <= 32'h0;
      n_chip_o <= 6'h0;
    end
    else
    begin
      tgl_q <= ~tgl_q;
      if (tx_data_take_i && idx_q < 2'h2)
        idx_q <= idx_q + 2'h1;
      if (tx_chip_vld_i)
      begin
        chips_o  <= {chips_o[30:0], tx_chip_i};
        n_chip_o <= n_chip_o + 6'h1;
      end
    end
  end
endmodule // dsc_src_model

`default_nettype wire

// ### tb/test_dsc_unit.sv
// bench of the spreading code unit: code rows, then reset, registers, refusal
// assumes dsc_unit, dsc_src_model and dsc_unit_chk compiled first
`default_nettype none
`include "dsc_cfg.svh"

module test_dsc_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, chips;
  logic        err, go, clr, rx_last, tx_data_i, tx_data_vld_i, tx_data_take_o;
  logic        tx_chip_o, tx_chip_vld_o, tx_sym_start_o, rx_i_chip_i, rx_q_chip_i;
  logic        rx_chip_vld_i, rx_acq_o, rx_sym_vld_o, rx_data_o;
  logic [5:0]  n_chip;
  int          failures = 0;
  int          n_tests = 0;
  // *****
  // code rows: register value, length select, mode, chips, expected code
  // *****
  typedef struct {logic [15:0] code; logic [1:0] sel; logic [1:0] mode; int len;
                  logic [15:0] exp;} dsc_row_t;
  dsc_row_t rows [7] = '{
    '{16'hF712, 2'h0, 2'h0, 11, 16'h0712},  // 11 chips, junk above
    '{16'hFF28, 2'h1, 2'h0, 13, 16'h1F28},  // 13 chips
    '{16'h8ABC, 2'h2, 2'h0, 15, 16'h0ABC},
    '{16'hC35A, 2'h3, 2'h0, 16, 16'hC35A},
    '{16'h00ED, 2'h0, 2'h3, 11, 16'h00ED},  // alternate programmable mode, 11 chips
    '{16'h0000, 2'h3, 2'h1, 7, 16'h0017},   // m7
    '{16'h0000, 2'h0, 2'h2, 15, 16'h09AF}}; // m15 from seed 1000

  dsc_unit DUT (.core_clk_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_data_i, .tx_data_vld_i, .tx_data_take_o,
    .tx_chip_o, .tx_chip_vld_o, .tx_sym_start_o, .rx_i_chip_i, .rx_q_chip_i,
    .rx_chip_vld_i, .rx_acq_o, .rx_sym_vld_o, .rx_data_o);
  dsc_src_model u_src (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .go_i(go),
    .clr_i(clr), .tx_data_take_i(tx_data_take_o), .tx_chip_i(tx_chip_o),
    .tx_chip_vld_i(tx_chip_vld_o), .tx_data_o(tx_data_i), .tx_data_vld_o(tx_data_vld_i),
    .rx_i_o(rx_i_chip_i), .rx_q_o(rx_q_chip_i), .rx_vld_o(rx_chip_vld_i),
    .chips_o(chips), .n_chip_o(n_chip));

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // latest decided receive bit
  // cleared with the model so a stale decision cannot pass a later row
  always_ff @(posedge core_clk_i)
  begin
    if (clr)
      rx_last <= 1'b0;
    else if (rx_sym_vld_o)
      rx_last <= rx_data_o;
  end

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge core_clk_i);
    if (k == 20)
    begin
      failures++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // spread bits 0 then 1, compare chips, and the receive decision for programmable-mode rows only
  task automatic run_row(input dsc_row_t r);
    logic [31:0] e;
    int k;
    e = 32'h0;
    for (int b = 0; b < 2; b++)
      for (int i = r.len - 1; i >= 0; i--)
        e = {e[30:0], b[0] ^ r.exp[i]};
    clr <= 1'b1;
    apb(1'b1, `DSC_OFF_TX_HI, {24'h0, r.code[15:8]});
    clr <= 1'b0;
    apb(1'b1, `DSC_OFF_TX_LO, {24'h0, r.code[7:0]});
    apb(1'b1, `DSC_OFF_RX_HI, {24'h0, r.code[15:8]});
    apb(1'b1, `DSC_OFF_RX_LO, {24'h0, r.code[7:0]});
    apb(1'b1, `DSC_OFF_CTRL, {24'h0, 1'b1, r.sel, 1'b0, r.sel, r.mode});
    go <= 1'b1;
    for (k = 0; k < 400 && n_chip != 6'(2 * r.len); k++)
      @(posedge core_clk_i);
    if (k == 400)
    begin
      failures++;
      report_and_stop();
    end
    repeat (40)
      @(posedge core_clk_i);
    chk(chips, e);
    chk(32'(n_chip), 32'(2 * r.len));
    if (r.mode[1] == r.mode[0])
    begin
      chk(32'(rx_acq_o), 32'h1);
      chk(32'(rx_last), 32'h1);
      // status: idle transmitter, inverted code decided, locked
      apb(1'b0, `DSC_OFF_STATUS, 32'h0);
      chk(rd, 32'h3);
    end
    go <= 1'b0;
    apb(1'b1, `DSC_OFF_CTRL, 32'h0);
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    {psel, penable, pwrite, go, clr} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (10)
      @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i])
      run_row(rows[i]);
    // second reset, then reset values
    sys_rst_i <= 1'b1;
    repeat (10)
      @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      apb(1'b0, 12'(4 * a), 32'h0);
      chk(rd, (a == 5) ? {27'h0, `DSC_RST_THRESH} : 32'h0);
    end
    apb(1'b1, `DSC_OFF_TX_LO, 32'h123456C3);
    apb(1'b0, `DSC_OFF_TX_LO, 32'h0);
    chk(rd, 32'hC3);
    apb(1'b1, 12'h01C, 32'hFF);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h01C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // enabled with no data: no chips may leave
    clr <= 1'b1;
    apb(1'b1, `DSC_OFF_CTRL, 32'h80);
    clr <= 1'b0;
    repeat (60)
      @(posedge core_clk_i);
    chk(32'(n_chip), 32'h0);
    report_and_stop();
  end
endmodule // test_dsc_unit

bind dsc_unit dsc_unit_chk u_chk (.core_clk_i, .sys_rst_i, .psel, .penable, .pready,
  .pslverr, .tx_data_vld_i, .tx_data_take_o, .tx_chip_vld_o, .tx_sym_start_o,
  .rx_chip_vld_i, .rx_sym_vld_o);

`default_nettype wire
